// [hdl/sfr_pkg.sv]
package sfr_pkg;

  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_FAST_X = 8'h0C;
  localparam logic [7:0] OP_DUAL = 8'h3B;
  localparam logic [7:0] OP_DUAL_X = 8'h3C;
  localparam logic [7:0] OP_QUAD = 8'h6B;
  localparam logic [7:0] OP_QUAD_X = 8'h6C;
  localparam logic [7:0] OP_DIO = 8'hBB;
  localparam logic [7:0] OP_DIO_X = 8'hBC;
  localparam logic [7:0] OP_QIO = 8'hEB;

  localparam logic [5:0] CMD_CLKS = 6'h08;
  localparam int BUF_AW = 12;
  localparam logic [BUF_AW-1:0] BUF_END = 12'h880;
  localparam logic [BUF_AW-1:0] BUF_LAST = 12'h87F;

  // Dummy clock counts: first of each pair is buffer read mode, second sequential.
  localparam logic [5:0] DMY_FAST_BUF = 6'h08;
  localparam logic [5:0] DMY_FAST_SEQ = 6'h20;
  localparam logic [5:0] DMY_X_BUF = 6'h18;
  localparam logic [5:0] DMY_X_SEQ = 6'h28;
  localparam logic [5:0] DMY_DIO_BUF = 6'h04;
  localparam logic [5:0] DMY_DIO_SEQ = 6'h10;
  localparam logic [5:0] DMY_DIOX_BUF = 6'h0C;
  localparam logic [5:0] DMY_DIOX_SEQ = 6'h14;
  localparam logic [5:0] DMY_QIO_BUF = 6'h04;
  localparam logic [5:0] DMY_QIO_SEQ = 6'h0C;

  localparam int CORE_PERIOD_NS = 8;
  localparam int SCLK_PERIOD_NS = 64;
  localparam logic [3:0] HALF_M1 = 4'(SCLK_PERIOD_NS / (2 * CORE_PERIOD_NS) - 1);

  localparam logic [2:0] LANE1 = 3'h1;
  localparam logic [2:0] LANE2 = 3'h2;
  localparam logic [2:0] LANE4 = 3'h4;

  typedef enum logic [2:0] {
    DP_CMD = 3'b000,
    DP_ADDR = 3'b001,
    DP_DUMMY = 3'b010,
    DP_DATA = 3'b011,
    DP_IGNORE = 3'b100
  } sfr_dphase_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_CMD = 3'b001,
    HS_ADDR = 3'b010,
    HS_DUMMY = 3'b011,
    HS_DATA = 3'b100,
    HS_END = 3'b101
  } sfr_hstate_t;

  function automatic logic is_known(input logic [7:0] op);
    case (op)
      OP_FAST, OP_FAST_X, OP_DUAL, OP_DUAL_X, OP_QUAD, OP_QUAD_X, OP_DIO, OP_DIO_X,
      OP_QIO: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_known

  function automatic logic is_quad(input logic [7:0] op);
    return (op == OP_QUAD) || (op == OP_QUAD_X) || (op == OP_QIO);
  endfunction : is_quad

  function automatic logic [2:0] addr_lanes(input logic [7:0] op);
    case (op)
      OP_DIO, OP_DIO_X: return LANE2;
      OP_QIO: return LANE4;
      default: return LANE1;
    endcase
  endfunction : addr_lanes

  function automatic logic [2:0] data_lanes(input logic [7:0] op);
    case (op)
      OP_DUAL, OP_DUAL_X, OP_DIO, OP_DIO_X: return LANE2;
      OP_QUAD, OP_QUAD_X, OP_QIO: return LANE4;
      default: return LANE1;
    endcase
  endfunction : data_lanes

  function automatic logic [5:0] dummy_clks(input logic [7:0] op, input logic buf_mode);
    case (op)
      OP_FAST, OP_DUAL, OP_QUAD: return buf_mode ? DMY_FAST_BUF : DMY_FAST_SEQ;
      OP_FAST_X, OP_DUAL_X, OP_QUAD_X: return buf_mode ? DMY_X_BUF : DMY_X_SEQ;
      OP_DIO: return buf_mode ? DMY_DIO_BUF : DMY_DIO_SEQ;
      OP_DIO_X: return buf_mode ? DMY_DIOX_BUF : DMY_DIOX_SEQ;
      default: return buf_mode ? DMY_QIO_BUF : DMY_QIO_SEQ;
    endcase
  endfunction : dummy_clks

  // Clocks needed for the 16-bit column field and for one byte.
  function automatic logic [5:0] addr_clks(input logic [2:0] lanes);
    case (lanes)
      LANE4: return 6'h04;
      LANE2: return 6'h08;
      default: return 6'h10;
    endcase
  endfunction : addr_clks

  function automatic logic [3:0] byte_clks(input logic [2:0] lanes);
    case (lanes)
      LANE4: return 4'h2;
      LANE2: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction : byte_clks

  // Single-line output travels on IO1 from the device and on IO0 from the host.
  function automatic logic [3:0] lane_drive(input logic [3:0] top, input logic [2:0] lanes,
                                            input logic on_io1);
    case (lanes)
      LANE4: return top;
      LANE2: return {2'b00, top[3:2]};
      default: return on_io1 ? {2'b00, top[3], 1'b0} : {3'b000, top[3]};
    endcase
  endfunction : lane_drive

  function automatic logic [3:0] lane_mask(input logic [2:0] lanes, input logic on_io1);
    case (lanes)
      LANE4: return 4'hF;
      LANE2: return 4'h3;
      default: return on_io1 ? 4'h2 : 4'h1;
    endcase
  endfunction : lane_mask

  function automatic logic [7:0] shift_out(input logic [7:0] v, input logic [2:0] lanes);
    case (lanes)
      LANE4: return {v[3:0], 4'h0};
      LANE2: return {v[5:0], 2'b00};
      default: return {v[6:0], 1'b0};
    endcase
  endfunction : shift_out

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic [3:0] io,
                                          input logic [2:0] lanes);
    case (lanes)
      LANE4: return {v[3:0], io};
      LANE2: return {v[5:0], io[1:0]};
      default: return {v[6:0], io[1]};
    endcase
  endfunction : shift_in

endpackage : sfr_pkg

// [hdl/sfr_link_if.sv]
`timescale 1ns/1ps
interface sfr_link_if;
  logic sclk;
  logic cs_n;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] io;

  // Undriven lines read high, as with pull-ups on the board.
  assign io = (dev_io_oe & dev_io_o) | (~dev_io_oe & host_io_oe & host_io_o) |
              (~dev_io_oe & ~host_io_oe);

  modport dev (
    input sclk,
    input cs_n,
    input io,
    output dev_io_o,
    output dev_io_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output host_io_o,
    output host_io_oe,
    input io
  );
endinterface : sfr_link_if

// [hdl/sfr_dev.sv]
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] 0Ch: command, 16-bit column, 24 dummies (buffer)
// [RULE2] 0Ch sequential mode uses 40 dummy clocks
// [RULE3] Bytes driven on falling edge, MSB first
// [RULE4] Buffer address advances after every byte
// [RULE5] Chip select high ends the transfer
// [RULE6] Buffer mode starts at column, stops at end
// [RULE7] Buffer mode: lines released after last byte
// [RULE8] Sequential mode ignores column, starts at zero
// [RULE9] Sequential mode wraps into next page
// [RULE10] 3Bh returns data on two lines
// [RULE11] 3Ch extended dummies, data on two lines
// [RULE12] 6Bh returns data on four lines
// [RULE13] 6Ch extended dummies, data on four lines
// [RULE14] Protect enable refuses all quad reads
// [RULE15] BBh: column and dummies two bits per clock
// [RULE16] BCh: like BBh with extended dummies
// [RULE17] EBh: column in and data out on four lines
// [RULE18] 0Bh: 8 dummies buffer, 32 sequential
// [RULE19] Host loads page and waits before reading
// [RULE20] Sample on rising edge; released while deselected
// [RULE21] Multi-line dummy counts are shared constants
module sfr_dev (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic buf_wr_en,
  input wire logic [sfr_pkg::BUF_AW-1:0] buf_wr_addr,
  input wire logic [7:0] buf_wr_data,
  input wire logic buf_mode,
  input wire logic protect_en,
  output logic page_adv,
  output logic refused,
  sfr_link_if.dev lk
);
  import sfr_pkg::*;

  logic [7:0] buf_mem [BUF_END];
  logic buf_mode_r;
  logic prot_r;
  logic mode_s1_r;
  logic mode_s2_r;
  logic prot_s1_r;
  logic prot_s2_r;

  sfr_dphase_t phase_r;
  logic [7:0] op_r;
  logic [15:0] col_r;
  logic [5:0] cnt_r;
  logic mode_r;
  logic [5:0] cnt_inc;
  logic [7:0] op_nxt;
  logic [15:0] col_nxt;
  logic [2:0] al;
  logic [2:0] dl;
  logic decode_now;
  logic refuse_now;

  logic started_r;
  logic [BUF_AW-1:0] addr_r;
  logic [7:0] sh_r;
  logic [3:0] left_r;
  logic [3:0] io_o_r;
  logic [3:0] io_oe_r;
  logic [15:0] first_col;
  logic [15:0] cur_addr;
  logic in_buf;
  logic [7:0] rd_byte;
  logic [7:0] sh_nxt;
  logic load_now;

  logic page_tgl_r = 1'b0;
  logic refuse_tgl_r = 1'b0;
  logic [2:0] pg_sync_r;
  logic [2:0] rf_sync_r;
  logic page_adv_r;
  logic refused_r;

  // Core side: buffer image written while the link is idle (page load done).
  always_ff @(posedge core_clk) begin
    if (buf_wr_en && (buf_wr_addr < BUF_END)) begin
      buf_mem[buf_wr_addr] <= buf_wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      buf_mode_r <= 1'b1;
      prot_r <= 1'b0;
    end else begin
      buf_mode_r <= buf_mode;
      prot_r <= protect_en;
    end
  end

  // Configuration levels into the link domain.
  always_ff @(posedge lk.sclk) begin
    mode_s1_r <= buf_mode_r;
    mode_s2_r <= mode_s1_r;
    prot_s1_r <= prot_r;
    prot_s2_r <= prot_s1_r;
  end

  assign cnt_inc = cnt_r + 6'h01;
  assign op_nxt = {op_r[6:0], lk.io[0]};
  assign al = addr_lanes(op_r);
  assign dl = data_lanes(op_r);
  assign decode_now = (phase_r == DP_CMD) && (cnt_inc == CMD_CLKS);
  assign refuse_now = decode_now && is_quad(op_nxt) && prot_s2_r; // [RULE14]

  always_comb begin
    case (al)
      LANE4: col_nxt = {col_r[11:0], lk.io}; // [RULE17]
      LANE2: col_nxt = {col_r[13:0], lk.io[1:0]}; // [RULE15] [RULE16]
      default: col_nxt = {col_r[14:0], lk.io[0]};
    endcase
  end

  // Inputs are taken on the rising edge; a high chip select clears the frame.
  always_ff @(posedge lk.sclk or posedge lk.cs_n) begin // [RULE20] [RULE5]
    if (lk.cs_n) begin
      phase_r <= DP_CMD;
      op_r <= 8'h00;
      col_r <= 16'h0000;
      cnt_r <= 6'h00;
      mode_r <= 1'b1;
    end else begin
      cnt_r <= cnt_inc;
      case (phase_r)
        DP_CMD: begin
          op_r <= op_nxt;
          if (decode_now) begin
            cnt_r <= 6'h00;
            mode_r <= mode_s2_r;
            if (!is_known(op_nxt) || refuse_now) begin // [RULE14]
              phase_r <= DP_IGNORE;
            end else begin
              phase_r <= DP_ADDR;
            end
          end
        end
        DP_ADDR: begin
          col_r <= col_nxt;
          if (cnt_inc == addr_clks(al)) begin
            cnt_r <= 6'h00;
            phase_r <= DP_DUMMY;
          end
        end
        DP_DUMMY: begin
          // Count depends on opcode and mode. [RULE1] [RULE2] [RULE18] [RULE21]
          if (cnt_inc == dummy_clks(op_r, mode_r)) begin
            cnt_r <= 6'h00;
            phase_r <= DP_DATA;
          end
        end
        DP_DATA, DP_IGNORE: begin
          cnt_r <= cnt_r;
        end
        default: begin
          phase_r <= DP_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge lk.sclk) begin
    if (refuse_now) begin
      refuse_tgl_r <= ~refuse_tgl_r;
    end
  end

  assign first_col = mode_r ? col_r : 16'h0000; // [RULE6] [RULE8]
  assign cur_addr = started_r ? {4'h0, addr_r} : first_col;
  assign in_buf = cur_addr < {4'h0, BUF_END};
  assign rd_byte = in_buf ? buf_mem[cur_addr[BUF_AW-1:0]] : 8'hFF;
  assign sh_nxt = shift_out(sh_r, dl);
  assign load_now = (phase_r == DP_DATA) && (left_r == 4'h0);

  // Output side runs on the falling edge and is released by chip select.
  always_ff @(negedge lk.sclk or posedge lk.cs_n) begin // [RULE20] [RULE5]
    if (lk.cs_n) begin
      started_r <= 1'b0;
      addr_r <= '0;
      sh_r <= 8'h00;
      left_r <= 4'h0;
      io_o_r <= 4'h0;
      io_oe_r <= 4'h0;
    end else if (load_now) begin
      started_r <= 1'b1;
      if (in_buf) begin
        // Lane count follows the opcode. [RULE10] [RULE11] [RULE12] [RULE13]
        sh_r <= rd_byte;
        io_o_r <= lane_drive(rd_byte[7:4], dl, 1'b1); // [RULE3]
        io_oe_r <= lane_mask(dl, 1'b1);
        left_r <= byte_clks(dl) - 4'h1;
        if (cur_addr[BUF_AW-1:0] == BUF_LAST) begin
          addr_r <= mode_r ? BUF_END : '0; // [RULE6] [RULE9]
        end else begin
          addr_r <= cur_addr[BUF_AW-1:0] + 12'h001; // [RULE4]
        end
      end else begin
        // A column past the buffer end must never fall back to byte zero.
        addr_r <= BUF_END; // [RULE7]
        io_oe_r <= 4'h0; // [RULE7]
      end
    end else if (phase_r == DP_DATA) begin
      sh_r <= sh_nxt;
      io_o_r <= lane_drive(sh_nxt[7:4], dl, 1'b1); // [RULE3]
      left_r <= left_r - 4'h1;
    end
  end

  // Sequential mode moves on to the next page once the last buffer byte goes out.
  always_ff @(negedge lk.sclk) begin
    if (!lk.cs_n && load_now && in_buf && !mode_r && (cur_addr[BUF_AW-1:0] == BUF_LAST)) begin
      page_tgl_r <= ~page_tgl_r; // [RULE9]
    end
  end

  // Link events into the core domain.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pg_sync_r <= 3'h0;
      rf_sync_r <= 3'h0;
      page_adv_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      pg_sync_r <= {pg_sync_r[1:0], page_tgl_r};
      rf_sync_r <= {rf_sync_r[1:0], refuse_tgl_r};
      page_adv_r <= pg_sync_r[2] ^ pg_sync_r[1];
      refused_r <= rf_sync_r[2] ^ rf_sync_r[1];
    end
  end

  assign lk.dev_io_o = io_o_r;
  assign lk.dev_io_oe = io_oe_r;
  assign page_adv = page_adv_r;
  assign refused = refused_r;

endmodule : sfr_dev

// [hdl/sfr_host.sv]
`timescale 1ns/1ps
module sfr_host (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] op,
  input wire logic [15:0] col,
  input wire logic buf_mode,
  input wire logic [15:0] nbytes,
  output logic busy,
  output logic rd_valid,
  output logic [7:0] rd_data,
  sfr_link_if.host lk
);
  import sfr_pkg::*;

  sfr_hstate_t st_r;
  logic [7:0] op_r;
  logic mode_r;
  logic [23:0] tx_r;
  logic [15:0] nb_r;
  logic [5:0] cnt_r;
  logic [3:0] bit_r;
  logic [7:0] rx_r;
  logic [3:0] div_r;
  logic sclk_r;
  logic cs_n_r;
  logic busy_r;
  logic [3:0] io_o_r;
  logic [3:0] io_oe_r;
  logic rd_valid_r;
  logic [7:0] rd_data_r;
  logic [3:0] io_s1_r;
  logic [3:0] io_s2_r;
  logic tick;
  logic rise;
  logic fall;
  logic [5:0] cnt_inc;
  logic [3:0] bit_inc;
  logic [2:0] al;
  logic [2:0] dl;
  logic [2:0] tl;
  logic [7:0] rx_nxt;
  logic [23:0] tx_nxt;
  logic [2:0] st_lanes;

  always_ff @(posedge core_clk) begin
    io_s1_r <= lk.io;
    io_s2_r <= io_s1_r;
  end

  assign tick = (div_r == HALF_M1);
  assign rise = tick && !sclk_r && (st_r != HS_IDLE) && (st_r != HS_END);
  assign fall = tick && sclk_r;
  assign cnt_inc = cnt_r + 6'h01;
  assign bit_inc = bit_r + 4'h1;
  assign al = addr_lanes(op_r);
  assign dl = data_lanes(op_r);
  assign tl = (st_r == HS_CMD) ? LANE1 : al;
  assign rx_nxt = shift_in(rx_r, io_s2_r, dl);
  assign st_lanes = (st_r == HS_CMD) ? LANE1 : al;

  always_comb begin
    case (tl)
      LANE4: tx_nxt = {tx_r[19:0], 4'h0};
      LANE2: tx_nxt = {tx_r[21:0], 2'b00};
      default: tx_nxt = {tx_r[22:0], 1'b0};
    endcase
  end

  // Link clock is the core clock divided; it idles low outside a frame.
  always_ff @(posedge core_clk) begin
    if (rst || (st_r == HS_IDLE)) begin
      div_r <= 4'h0;
      sclk_r <= 1'b0;
    end else begin
      div_r <= tick ? 4'h0 : div_r + 4'h1;
      if (tick && (sclk_r || (st_r != HS_END))) begin
        sclk_r <= ~sclk_r;
      end
    end
  end

  // Sequence advances and data is captured on each rising link edge.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= HS_IDLE;
      op_r <= 8'h00;
      mode_r <= 1'b1;
      tx_r <= 24'h000000;
      nb_r <= 16'h0000;
      cnt_r <= 6'h00;
      bit_r <= 4'h0;
      rx_r <= 8'h00;
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      rd_valid_r <= 1'b0;
      case (st_r)
        HS_IDLE: begin
          if (start) begin // [RULE19]
            st_r <= HS_CMD;
            op_r <= op;
            mode_r <= buf_mode;
            nb_r <= nbytes;
            tx_r <= {op, col};
            cnt_r <= 6'h00;
            bit_r <= 4'h0;
          end
        end
        HS_CMD: begin
          if (rise) begin
            tx_r <= tx_nxt;
            cnt_r <= cnt_inc;
            if (cnt_inc == CMD_CLKS) begin
              cnt_r <= 6'h00;
              st_r <= HS_ADDR;
            end
          end
        end
        HS_ADDR: begin
          if (rise) begin
            tx_r <= tx_nxt; // [RULE15] [RULE16] [RULE17]
            cnt_r <= cnt_inc;
            if (cnt_inc == addr_clks(al)) begin
              cnt_r <= 6'h00;
              st_r <= HS_DUMMY;
            end
          end
        end
        HS_DUMMY: begin
          if (rise) begin
            cnt_r <= cnt_inc;
            if (cnt_inc == dummy_clks(op_r, mode_r)) begin // [RULE1] [RULE2] [RULE18] [RULE21]
              cnt_r <= 6'h00;
              st_r <= (nb_r == 16'h0000) ? HS_END : HS_DATA;
            end
          end
        end
        HS_DATA: begin
          if (rise) begin
            rx_r <= rx_nxt; // [RULE20]
            bit_r <= bit_inc;
            if (bit_inc == byte_clks(dl)) begin
              bit_r <= 4'h0;
              rd_valid_r <= 1'b1;
              rd_data_r <= rx_nxt;
              nb_r <= nb_r - 16'h0001;
              if (nb_r == 16'h0001) begin
                st_r <= HS_END;
              end
            end
          end
        end
        HS_END: begin
          if (tick && !sclk_r) begin
            st_r <= HS_IDLE;
          end
        end
        default: begin
          st_r <= HS_IDLE;
        end
      endcase
    end
  end

  // Pins change on the falling link edge; chip select rises half a clock after the last fall.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_n_r <= 1'b1;
      busy_r <= 1'b0;
      io_o_r <= 4'h0;
      io_oe_r <= 4'h0;
    end else if ((st_r == HS_IDLE) && start) begin
      cs_n_r <= 1'b0;
      busy_r <= 1'b1;
      io_o_r <= lane_drive(op[7:4], LANE1, 1'b0);
      io_oe_r <= lane_mask(LANE1, 1'b0);
    end else if ((st_r == HS_END) && tick && !sclk_r) begin
      cs_n_r <= 1'b1; // [RULE5]
      busy_r <= 1'b0;
    end else if (fall) begin
      if ((st_r == HS_CMD) || (st_r == HS_ADDR)) begin
        io_o_r <= lane_drive(tx_r[23:20], st_lanes, 1'b0);
        io_oe_r <= lane_mask(st_lanes, 1'b0);
      end else begin
        io_oe_r <= 4'h0;
      end
    end
  end

  assign lk.sclk = sclk_r;
  assign lk.cs_n = cs_n_r;
  assign lk.host_io_o = io_o_r;
  assign lk.host_io_oe = io_oe_r;
  assign busy = busy_r;
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;

endmodule : sfr_host

// [testbench/sfr_asserts.sv]
`timescale 1ns/1ps
module sfr_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] host_io_o,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] io
);
  logic sclk_r;
  logic [15:0] rise_cnt_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  always_ff @(posedge core_clk) begin
    sclk_r <= sclk;
  end

  // Rising link clock edges seen since chip select fell.
  always_ff @(posedge core_clk) begin
    if (cs_n) begin
      rise_cnt_r <= '0;
    end else if (sclk && !sclk_r && rise_cnt_r != 16'hFFFF) begin
      rise_cnt_r <= rise_cnt_r + 16'h0001;
    end
  end

  deselect_release_a: assert property (cs_n |-> dev_io_oe == 4'h0 && host_io_oe == 4'h0)
    else $error("lines driven while deselected");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("link clock not idle low while deselected");
  sclk_half_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high phase not four core cycles");
  no_contention_a: assert property ((dev_io_oe & host_io_oe) == 4'h0)
    else $error("both ends drive one line");
  cmd_phase_a: assert property (!cs_n && rise_cnt_r < 16'h0008 |->
      host_io_oe == 4'h1 && dev_io_oe == 4'h0)
    else $error("command phase not on one host line");
  min_latency_a: assert property (dev_io_oe != 4'h0 |-> rise_cnt_r >= 16'h0010)
    else $error("device drives before address and dummies end");
  lane_set_a: assert property (dev_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("device drives an illegal lane set");
  dev_fall_a: assert property (!cs_n && !$past(cs_n) &&
      ($changed(dev_io_oe) || $changed(dev_io_o & dev_io_oe)) |-> $fell(sclk))
    else $error("device output changed off the falling edge");
  host_fall_a: assert property (!cs_n && !$past(cs_n) &&
      ($changed(host_io_oe) || $changed(host_io_o & host_io_oe)) |-> $fell(sclk))
    else $error("host output changed off the falling edge");
  line_level_a: assert property ((io & dev_io_oe) == (dev_io_o & dev_io_oe))
    else $error("driven device level not on the line");

  cover property (dev_io_oe == 4'h2);
  cover property (dev_io_oe == 4'h3);
  cover property (dev_io_oe == 4'hF);
endmodule : sfr_asserts

// [testbench/sfr_tb.sv]
`timescale 1ns/1ps
module sfr_tb;
  import sfr_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic buf_wr_en = 1'b0;
  logic [BUF_AW-1:0] buf_wr_addr = '0;
  logic [7:0] buf_wr_data = 8'h00;
  logic buf_mode = 1'b1;
  logic protect_en = 1'b0;
  logic start = 1'b0;
  logic [7:0] op = 8'h0B;
  logic [15:0] col = 16'h0000;
  logic [15:0] nbytes = 16'h0000;
  logic page_adv;
  logic refused;
  logic busy;
  logic rd_valid;
  logic [7:0] rd_data;
  logic [7:0] mem [0:2175];
  logic [7:0] exp_q [$];
  logic [7:0] ops [9] = '{OP_FAST, OP_FAST_X, OP_DUAL, OP_DUAL_X, OP_QUAD, OP_QUAD_X,
                          OP_DIO, OP_DIO_X, OP_QIO};
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_rx = 0;
  int n_adv = 0;
  int n_ref = 0;
  int cyc = 0;

  sfr_link_if sfr_link_if_i ();
  sfr_dev sfr_dev_i (.core_clk(core_clk), .rst(rst), .buf_wr_en(buf_wr_en),
    .buf_wr_addr(buf_wr_addr), .buf_wr_data(buf_wr_data), .buf_mode(buf_mode),
    .protect_en(protect_en), .page_adv(page_adv), .refused(refused), .lk(sfr_link_if_i));
  sfr_host sfr_host_i (.core_clk(core_clk), .rst(rst), .start(start), .op(op), .col(col),
    .buf_mode(buf_mode), .nbytes(nbytes), .busy(busy), .rd_valid(rd_valid),
    .rd_data(rd_data), .lk(sfr_link_if_i));
  sfr_asserts sfr_asserts_i (.core_clk(core_clk), .rst(rst), .sclk(sfr_link_if_i.sclk),
    .cs_n(sfr_link_if_i.cs_n), .dev_io_o(sfr_link_if_i.dev_io_o),
    .dev_io_oe(sfr_link_if_i.dev_io_oe), .host_io_o(sfr_link_if_i.host_io_o),
    .host_io_oe(sfr_link_if_i.host_io_oe), .io(sfr_link_if_i.io));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task conclude;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: read byte %h, expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_n(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      n_mismatch++;
      $display("wrong value at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask : chk_n

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 100000) begin
      n_mismatch++;
      conclude();
    end
  end

  // Every byte the host delivers is checked against the model in arrival order.
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) begin
      n_rx++;
      if (exp_q.size() == 0) begin
        chk_n(1, 0);
      end else begin
        chk8(rd_data, exp_q.pop_front());
      end
    end
    if (page_adv === 1'b1) begin
      n_adv++;
    end
    if (refused === 1'b1) begin
      n_ref++;
    end
  end

  task automatic setcfg(input logic m, input logic p);
    @(negedge core_clk);
    buf_mode = m;
    protect_en = p;
    repeat (4) @(negedge core_clk);
  endtask : setcfg

  // Reads n bytes; the model gives pull-up ones wherever the device stays silent.
  task automatic rd(input logic [7:0] o, input logic [15:0] c, input int n);
    int k;
    int a;
    logic qd;
    logic ig;
    k = 0;
    qd = protect_en && (o == OP_QUAD || o == OP_QUAD_X || o == OP_QIO);
    ig = 1'b1;
    foreach (ops[q]) begin
      if (ops[q] == o) begin
        ig = 1'b0;
      end
    end
    n_rx = 0;
    n_ref = 0;
    for (int i = 0; i < n; i++) begin
      a = buf_mode ? int'(c) + i : i % 2176;
      exp_q.push_back((qd || ig || a > 2175) ? 8'hFF : mem[a]);
    end
    @(negedge core_clk);
    op = o;
    col = c;
    nbytes = 16'(n);
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    while (busy === 1'b1 && k < 60000) begin
      @(negedge core_clk);
      k++;
    end
    chk_n(n_rx, n);
    chk_n(n_ref, qd ? 1 : 0);
  endtask : rd

  initial begin
    void'($urandom(32'h8527));
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 2177; i++) begin
      @(negedge core_clk);
      buf_wr_en = 1'b1;
      buf_wr_addr = BUF_AW'(i);
      buf_wr_data = 8'($urandom);
      if (i < 2176) begin
        mem[i] = buf_wr_data;
      end
    end
    @(negedge core_clk);
    buf_wr_en = 1'b0;
    for (int m = 1; m >= 0; m--) begin
      setcfg(m[0], 1'b0);
      for (int j = 0; j < 9; j++) begin
        rd(ops[j], 16'($urandom_range(2175)), 3);
      end
    end
    setcfg(1'b1, 1'b0);
    rd(OP_DUAL_X, 16'h087E, 4);
    rd(OP_FAST, 16'h0900, 2);
    rd(OP_FAST, 16'h0005, 0);
    rd(OP_FAST, 16'h0005, 1);
    rd(8'hA5, 16'h0010, 2);
    setcfg(1'b1, 1'b1);
    rd(OP_QIO, 16'h0010, 2);
    rd(OP_QUAD_X, 16'h0010, 2);
    rd(OP_DIO, 16'h0020, 2);
    setcfg(1'b0, 1'b0);
    n_adv = 0;
    rd(OP_QUAD, 16'h0000, 2178);
    chk_n(n_adv, 1);
    conclude();
  end
endmodule : sfr_tb
